// [include/eac_pkg.sv]
package eac_pkg;

	// ==========================================================
	// storage geometry
	localparam int NV_DEPTH    = 512;
	localparam int NV_ADDR_W   = 9;
	localparam int NV_DATA_W   = 8;
	localparam int IO_ADDR_W   = 7;

	// ==========================================================
	// register map, i/o space offsets
	localparam logic [6:0] OFS_CONTROL      = 7'h1c;
	localparam logic [6:0] OFS_DATA         = 7'h1d;
	localparam logic [6:0] OFS_ADDRESS_LOW  = 7'h1e;
	localparam logic [6:0] OFS_ADDRESS_HIGH = 7'h1f;
	localparam logic [6:0] IO_SPACE_TOP     = 7'h3f;
	localparam logic [6:0] DATA_SPACE_SHIFT = 7'h20;

	// ==========================================================
	// control register fields
	localparam int CTL_READ_STROBE   = 0;
	localparam int CTL_WRITE_STROBE  = 1;
	localparam int CTL_MASTER_WE     = 2;
	localparam int CTL_READY_IRQ_EN  = 3;
	localparam int ADDR_HIGH_BIT     = 0;

	// ==========================================================
	// timing
	localparam int         CLK_PERIOD_NS    = 100;
	localparam int         OSC_PERIOD_NS    = 1000;
	localparam int         OSC_DIV          = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int         OSC_DIV_W        = 4;
	localparam int         WRITE_OSC_CYCLES = 8448;
	localparam int         WRITE_TIME_US    = 8500;
	localparam int         WR_CNT_W         = 14;
	localparam logic [2:0] MWE_TIMEOUT      = 3'h4;
	localparam logic [2:0] RD_STALL         = 3'h4;
	localparam logic [2:0] WR_STALL         = 3'h2;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		EAC_SEL_NONE,
		EAC_SEL_CONTROL,
		EAC_SEL_DATA,
		EAC_SEL_ADDR_LOW,
		EAC_SEL_ADDR_HIGH
	} eac_sel_e;

	typedef struct packed {
		logic                 wr;
		logic                 rd;
		logic                 data_space;
		logic [IO_ADDR_W-1:0] addr;
		logic [7:0]           wdata;
	} eac_io_req_s;

	// ==========================================================
	// register select from an i/o or data space address
	function automatic eac_sel_e eac_decode(input eac_io_req_s req);
		logic [6:0] a;
		eac_sel_e   sel;
		a   = req.data_space ? 7'(req.addr - DATA_SPACE_SHIFT) : req.addr;
		sel = EAC_SEL_NONE;
		if (req.data_space ? (req.addr >= DATA_SPACE_SHIFT) : (req.addr <= IO_SPACE_TOP)) begin
			case (a)
				OFS_CONTROL:      sel = EAC_SEL_CONTROL;
				OFS_DATA:         sel = EAC_SEL_DATA;
				OFS_ADDRESS_LOW:  sel = EAC_SEL_ADDR_LOW;
				OFS_ADDRESS_HIGH: sel = EAC_SEL_ADDR_HIGH;
				default:          sel = EAC_SEL_NONE;
			endcase
		end
		return sel;
	endfunction : eac_decode

endpackage : eac_pkg

// [hdl/eac_mem.sv]
`timescale 1ns/1ps
module eac_mem (
	// clock
	input  wire logic                          clk_sys,
	// write port
	input  wire logic                          wr_en,
	input  wire logic [eac_pkg::NV_ADDR_W-1:0] wr_addr,
	input  wire logic [eac_pkg::NV_DATA_W-1:0] wr_data,
	// read port
	input  wire logic                          rd_en,
	input  wire logic [eac_pkg::NV_ADDR_W-1:0] rd_addr,
	output logic      [eac_pkg::NV_DATA_W-1:0] rd_data
);

	// ==========================================================
	// byte array
	logic [eac_pkg::NV_DATA_W-1:0] cells [eac_pkg::NV_DEPTH];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rd_en) begin
			rd_data <= cells[rd_addr];
		end
	end

endmodule : eac_mem

// [hdl/eac_wtimer.sv]
`timescale 1ns/1ps
module eac_wtimer #(
	parameter int WRITE_OSC_CYCLES = eac_pkg::WRITE_OSC_CYCLES
) (
	// clock and power-on reset only
	input  wire logic clk_sys,
	input  wire logic pwr_rst_b,
	// control
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	// ==========================================================
	// free running 1 mhz tick from the system clock
	typedef enum {EAC_WT_IDLE, EAC_WT_PROG} eac_wt_e;

	localparam logic [eac_pkg::OSC_DIV_W-1:0] DIV_LAST = eac_pkg::OSC_DIV_W'(eac_pkg::OSC_DIV - 1);
	localparam logic [eac_pkg::WR_CNT_W-1:0]  OSC_LAST = eac_pkg::WR_CNT_W'(WRITE_OSC_CYCLES - 1);

	logic [eac_pkg::OSC_DIV_W-1:0] div_cnt;
	logic                          tick;
	logic [eac_pkg::WR_CNT_W-1:0]  osc_cnt;
	eac_wt_e                       state;

	always_ff @(posedge clk_sys) begin
		if (!pwr_rst_b || div_cnt == DIV_LAST) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	assign tick = (div_cnt == DIV_LAST);

	// ==========================================================
	// write length in oscillator cycles, untouched by system reset
	always_ff @(posedge clk_sys) begin
		done <= 1'b0;
		if (!pwr_rst_b) begin
			state   <= EAC_WT_IDLE;
			busy    <= 1'b0;
			osc_cnt <= '0;
		end else begin
			case (state)
				EAC_WT_IDLE: begin
					if (start) begin
						state   <= EAC_WT_PROG;
						busy    <= 1'b1;
						osc_cnt <= '0;
					end
				end
				EAC_WT_PROG: begin
					if (tick) begin
						if (osc_cnt == OSC_LAST) begin
							state <= EAC_WT_IDLE;
							busy  <= 1'b0;
							done  <= 1'b1;
						end else begin
							osc_cnt <= osc_cnt + 1'b1;
						end
					end
				end
				default: begin
					state <= EAC_WT_IDLE;
					busy  <= 1'b0;
				end
			endcase
		end
	end

endmodule : eac_wtimer

// [hdl/eac_top.sv]
// Function
// - 512 separate bytes, each read or written
// - 9-bit linear address, high bits read zero
// - address undefined after reset, software loads first
// - data register feeds writes, receives read bytes
// - ready interrupt level while idle, enabled, global
// - master write enable clears four cycles later
// - write strobe starts write only with master
// - no write start during flash programming
// - write strobe stays set until write ends
// - write lasts 8448 cycles of 1 MHz
// - write start stalls cpu two cycles
// - read strobe fetches byte, stalls four cycles
// - busy write ignores reads, locks address
// - control bits seven to four read zero
// - registers in i/o space, data space plus 0x20
// - running write survives reset with power good
`timescale 1ns/1ps
module eac_top #(
	parameter int WRITE_OSC_CYCLES = eac_pkg::WRITE_OSC_CYCLES
) (
	// clock and resets
	input  wire logic                 clk_sys,
	input  wire logic                 rst_b,
	input  wire logic                 pwr_rst_b,
	// cpu register port
	input  wire eac_pkg::eac_io_req_s io_req,
	output logic [7:0]                io_rdata,
	output logic                      cpu_stall,
	// cpu status
	input  wire logic                 global_irq_enable,
	input  wire logic                 flash_selfprog_enable,
	// interrupt request
	output logic                      ready_irq
);

	// ==========================================================
	// decode
	eac_pkg::eac_sel_e                sel_wr;
	eac_pkg::eac_sel_e                sel_rd;
	logic                             ctl_wr;
	logic                             write_start;
	logic                             read_start;
	logic                             write_busy;
	logic                             write_done;

	logic                             master_write_enable;
	logic [2:0]                       mwe_cnt;
	logic                             ready_irq_enable;
	logic [eac_pkg::NV_ADDR_W-1:0]    nv_address;
	logic [eac_pkg::NV_DATA_W-1:0]    nv_data;
	logic [eac_pkg::NV_ADDR_W-1:0]    prog_addr;
	logic [eac_pkg::NV_DATA_W-1:0]    prog_data;
	logic [eac_pkg::NV_DATA_W-1:0]    mem_rd_data;
	logic                             rd_pending;
	logic [2:0]                       stall_cnt;
	logic [2:0]                       next_stall_cnt;

	always_comb begin
		sel_wr = io_req.wr ? eac_pkg::eac_decode(io_req) : eac_pkg::EAC_SEL_NONE;
		sel_rd = io_req.rd ? eac_pkg::eac_decode(io_req) : eac_pkg::EAC_SEL_NONE;
	end

	assign ctl_wr = (sel_wr == eac_pkg::EAC_SEL_CONTROL);

	// start needs the master enable as it stood before this write
	assign write_start = rst_b && ctl_wr && io_req.wdata[eac_pkg::CTL_WRITE_STROBE]
		&& master_write_enable
		&& !write_busy
		&& !flash_selfprog_enable;

	assign read_start = rst_b && ctl_wr && io_req.wdata[eac_pkg::CTL_READ_STROBE]
		&& !write_busy;

	// ==========================================================
	// write timing engine, reset only by loss of power
	eac_wtimer #(
		.WRITE_OSC_CYCLES (WRITE_OSC_CYCLES)
	) u_wtimer (
		.clk_sys   (clk_sys),
		.pwr_rst_b (pwr_rst_b),
		.start     (write_start),
		.busy      (write_busy),
		.done      (write_done)
	);

	// ==========================================================
	// byte store
	eac_mem u_mem (
		.clk_sys (clk_sys),
		.wr_en   (write_done),
		.wr_addr (prog_addr),
		.wr_data (prog_data),
		.rd_en   (read_start),
		.rd_addr (nv_address),
		.rd_data (mem_rd_data)
	);

	// ==========================================================
	// master write enable with timeout
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			master_write_enable <= 1'b0;
			mwe_cnt             <= '0;
		end else if (ctl_wr && io_req.wdata[eac_pkg::CTL_MASTER_WE]) begin
			master_write_enable <= 1'b1;
			mwe_cnt             <= eac_pkg::MWE_TIMEOUT;
		end else if (master_write_enable) begin
			mwe_cnt <= mwe_cnt - 1'b1;
			if (mwe_cnt == 3'h1) begin
				master_write_enable <= 1'b0;
			end
		end
	end

	// ==========================================================
	// ready interrupt enable
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ready_irq_enable <= 1'b0;
		end else if (ctl_wr) begin
			ready_irq_enable <= io_req.wdata[eac_pkg::CTL_READY_IRQ_EN];
		end
	end

	// ==========================================================
	// address, left unset by reset and frozen during a write
	always_ff @(posedge clk_sys) begin
		if (sel_wr == eac_pkg::EAC_SEL_ADDR_LOW && !write_busy) begin
			nv_address[7:0] <= io_req.wdata;
		end
		if (sel_wr == eac_pkg::EAC_SEL_ADDR_HIGH && !write_busy) begin
			nv_address[8] <= io_req.wdata[eac_pkg::ADDR_HIGH_BIT];
		end
	end

	// ==========================================================
	// data register, fetched byte wins over a cpu write
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rd_pending <= 1'b0;
		end else begin
			rd_pending <= read_start;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rd_pending) begin
			nv_data <= mem_rd_data;
		end else if (sel_wr == eac_pkg::EAC_SEL_DATA) begin
			nv_data <= io_req.wdata;
		end
	end

	// target of a running write, kept across system reset
	always_ff @(posedge clk_sys) begin
		if (write_start) begin
			prog_addr <= nv_address;
			prog_data <= nv_data;
		end
	end

	// ==========================================================
	// cpu stall after strobes
	always_comb begin
		next_stall_cnt = stall_cnt;
		if (read_start) begin
			next_stall_cnt = eac_pkg::RD_STALL;
		end else if (write_start) begin
			next_stall_cnt = eac_pkg::WR_STALL;
		end else if (stall_cnt != 3'h0) begin
			next_stall_cnt = stall_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			stall_cnt <= '0;
			cpu_stall <= 1'b0;
		end else begin
			stall_cnt <= next_stall_cnt;
			cpu_stall <= (next_stall_cnt != 3'h0);
		end
	end

	// ==========================================================
	// ready interrupt, a level while no write runs
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ready_irq <= 1'b0;
		end else begin
			ready_irq <= ready_irq_enable && global_irq_enable && !write_busy && !write_start;
		end
	end

	// ==========================================================
	// register read back
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			io_rdata <= '0;
		end else begin
			case (sel_rd)
				eac_pkg::EAC_SEL_CONTROL: begin
					io_rdata <= '0;
					io_rdata[eac_pkg::CTL_READY_IRQ_EN] <= ready_irq_enable;
					io_rdata[eac_pkg::CTL_MASTER_WE]    <= master_write_enable;
					io_rdata[eac_pkg::CTL_WRITE_STROBE] <= write_busy;
				end
				eac_pkg::EAC_SEL_DATA: begin
					io_rdata <= nv_data;
				end
				eac_pkg::EAC_SEL_ADDR_LOW: begin
					io_rdata <= nv_address[7:0];
				end
				eac_pkg::EAC_SEL_ADDR_HIGH: begin
					io_rdata <= {7'h00, nv_address[8]};
				end
				default: begin
					io_rdata <= '0;
				end
			endcase
		end
	end

	// ==========================================================
	// checks
	default clocking cb_sys @(posedge clk_sys);
	endclocking

	default disable iff (!rst_b || !pwr_rst_b);

	property p_mwe_timeout;
		ctl_wr && io_req.wdata[eac_pkg::CTL_MASTER_WE]
			##1 (!(ctl_wr && io_req.wdata[eac_pkg::CTL_MASTER_WE])) [*4] |=> !master_write_enable;
	endproperty
	a_mwe_timeout: assert property (p_mwe_timeout) else $error("master write enable timeout wrong");

	property p_mwe_hold;
		ctl_wr && io_req.wdata[eac_pkg::CTL_MASTER_WE] |=> master_write_enable [*4];
	endproperty
	a_mwe_hold: assert property (p_mwe_hold) else $error("master write enable dropped early");

	property p_start_needs_mwe;
		write_start |-> master_write_enable && !write_busy;
	endproperty
	a_start_needs_mwe: assert property (p_start_needs_mwe) else $error("write started without master enable");

	property p_strobe_no_mwe;
		ctl_wr && io_req.wdata[eac_pkg::CTL_WRITE_STROBE] && !master_write_enable && !write_busy
			|=> !write_busy;
	endproperty
	a_strobe_no_mwe: assert property (p_strobe_no_mwe) else $error("strobe without master enable took effect");

	property p_busy_after_start;
		write_start |=> write_busy [*8];
	endproperty
	a_busy_after_start: assert property (p_busy_after_start) else $error("write strobe not held during write");

	property p_done_ends_busy;
		$fell(write_busy) |-> write_done;
	endproperty
	a_done_ends_busy: assert property (p_done_ends_busy) else $error("write strobe cleared before write end");

	property p_ctl_busy_readback;
		sel_rd == eac_pkg::EAC_SEL_CONTROL |=> io_rdata[eac_pkg::CTL_WRITE_STROBE] == $past(write_busy);
	endproperty
	a_ctl_busy_readback: assert property (p_ctl_busy_readback) else $error("write strobe reads wrong");

	property p_no_start_flash;
		flash_selfprog_enable |-> !write_start;
	endproperty
	a_no_start_flash: assert property (p_no_start_flash) else $error("write started during flash programming");

	property p_no_restart;
		write_busy |-> !write_start && !read_start;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("strobe accepted while busy");

	property p_read_ignored_busy;
		write_busy && ctl_wr && io_req.wdata[eac_pkg::CTL_READ_STROBE] && !cpu_stall |=> !cpu_stall;
	endproperty
	a_read_ignored_busy: assert property (p_read_ignored_busy) else $error("read during write stalled cpu");

	property p_addr_frozen;
		write_busy && (sel_wr == eac_pkg::EAC_SEL_ADDR_LOW || sel_wr == eac_pkg::EAC_SEL_ADDR_HIGH)
			|=> $stable(nv_address);
	endproperty
	a_addr_frozen: assert property (p_addr_frozen) else $error("address changed during write");

	property p_read_stall;
		read_start |=> cpu_stall [*4] ##1 !cpu_stall;
	endproperty
	a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles");

	property p_write_stall;
		write_start |=> cpu_stall [*2] ##1 !cpu_stall;
	endproperty
	a_write_stall: assert property (p_write_stall) else $error("write stall not two cycles");

	property p_read_data;
		read_start |-> ##2 nv_data == $past(mem_rd_data, 1);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read byte not loaded");

	property p_irq_level;
		ready_irq |-> $past(ready_irq_enable) && $past(global_irq_enable) && $past(!write_busy);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("ready interrupt raised wrongly");

	property p_irq_busy;
		write_busy |=> !ready_irq;
	endproperty
	a_irq_busy: assert property (p_irq_busy) else $error("ready interrupt during write");

	property p_irq_idle;
		ready_irq_enable && global_irq_enable && !write_busy && !write_start |=> ready_irq;
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("ready interrupt missing while idle");

	property p_ctl_reserved;
		sel_rd == eac_pkg::EAC_SEL_CONTROL |=> io_rdata[7:4] == 4'h0;
	endproperty
	a_ctl_reserved: assert property (p_ctl_reserved) else $error("control reserved bits not zero");

	property p_ctl_data_space;
		io_req.wr && io_req.data_space && io_req.addr == 7'(eac_pkg::OFS_CONTROL + eac_pkg::DATA_SPACE_SHIFT)
			|-> ctl_wr;
	endproperty
	a_ctl_data_space: assert property (p_ctl_data_space) else $error("data space control write missed");

	property p_addr_high_zero;
		sel_rd == eac_pkg::EAC_SEL_ADDR_HIGH |=> io_rdata[7:1] == 7'h00;
	endproperty
	a_addr_high_zero: assert property (p_addr_high_zero) else $error("high address upper bits not zero");

endmodule : eac_top

// [tb/eac_cpu.sv]
`timescale 1ns/1ps
module eac_cpu (
	// clock and status
	input  wire logic            clk_sys,
	input  wire logic            cpu_stall,
	input  wire logic            flash_selfprog_enable,
	// register port
	output eac_pkg::eac_io_req_s io_req,
	input  wire logic [7:0]      io_rdata
);
	// ==========================================================
	// one register access, held off while the core is stalled
	initial io_req = '0;

	task automatic acc(input logic w, input logic ds, input logic [6:0] a, input logic [7:0] v,
		output logic [7:0] r);
		@(posedge clk_sys);
		while (cpu_stall)
			@(posedge clk_sys);
		io_req <= '{w, ~w, ds, ds ? a + 7'h20 : a, v};
		@(posedge clk_sys);
		io_req <= '0;
		#1;
		r = io_rdata;
	endtask : acc

	// ==========================================================
	// software sequences for the store
	task automatic nv_idle();
		logic [7:0] r;
		r = 8'h02;
		while (r[1])
			acc(1'b0, 1'b0, eac_pkg::OFS_CONTROL, 8'h00, r);
	endtask : nv_idle

	task automatic nv_write(input logic ds, input logic [8:0] a, input logic [7:0] v);
		logic [7:0] r;
		nv_idle();
		while (flash_selfprog_enable)
			@(posedge clk_sys);
		acc(1'b1, ds, eac_pkg::OFS_ADDRESS_HIGH, {7'h00, a[8]}, r);
		acc(1'b1, ds, eac_pkg::OFS_ADDRESS_LOW, a[7:0], r);
		acc(1'b1, ds, eac_pkg::OFS_DATA, v, r);
		acc(1'b1, ds, eac_pkg::OFS_CONTROL, 8'h04, r);
		acc(1'b1, ds, eac_pkg::OFS_CONTROL, 8'h02, r);
	endtask : nv_write

	task automatic nv_read(input logic ds, input logic [8:0] a, output logic [7:0] v);
		logic [7:0] r;
		nv_idle();
		acc(1'b1, ds, eac_pkg::OFS_ADDRESS_HIGH, {7'h00, a[8]}, r);
		acc(1'b1, ds, eac_pkg::OFS_ADDRESS_LOW, a[7:0], r);
		acc(1'b1, ds, eac_pkg::OFS_CONTROL, 8'h01, r);
		acc(1'b0, ds, eac_pkg::OFS_DATA, 8'h00, v);
	endtask : nv_read
endmodule : eac_cpu

// [tb/eac_top_tb.sv]
`timescale 1ns/1ps
module eac_top_tb;
	// ==========================================================
	// signals
	logic                 clk_sys               = 1'b0;
	logic                 rst_b                 = 1'b0;
	logic                 pwr_rst_b             = 1'b0;
	logic                 global_irq_enable     = 1'b0;
	logic                 flash_selfprog_enable = 1'b0;
	eac_pkg::eac_io_req_s io_req;
	logic [7:0]           io_rdata;
	logic                 cpu_stall;
	logic                 ready_irq;
	logic [7:0]           d;
	logic [8:0]           adr [3] = '{9'h000, 9'h1ff, 9'h0a5};
	logic [7:0]           dat [3] = '{8'h3c, 8'hc3, 8'h5a};
	int                   n_mismatch = 0;
	int                   checked    = 0;
	int                   cycles     = 0;
	int                   stalls     = 0;
	int                   s0;
	int                   t0;

	always #50 clk_sys = ~clk_sys;

	eac_top #(.WRITE_OSC_CYCLES(10)) i_dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .pwr_rst_b(pwr_rst_b), .io_req(io_req), .io_rdata(io_rdata),
		.cpu_stall(cpu_stall), .global_irq_enable(global_irq_enable),
		.flash_selfprog_enable(flash_selfprog_enable), .ready_irq(ready_irq));

	eac_cpu i_cpu (
		.clk_sys(clk_sys), .cpu_stall(cpu_stall), .flash_selfprog_enable(flash_selfprog_enable),
		.io_req(io_req), .io_rdata(io_rdata));

	// ==========================================================
	// checking and closing
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic cmp_cnt(input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask : cmp_cnt

	task automatic stop_test();
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cpu_stall === 1'b1)
			stalls <= stalls + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ==========================================================
	// tests
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_b     <= 1'b1;
		pwr_rst_b <= 1'b1;
		#1;
		cmp(io_rdata, 8'h00);
		cmp({6'h00, cpu_stall, ready_irq}, 8'h00);
		i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_ADDRESS_HIGH, 8'hff, d);
		i_cpu.acc(1'b0, 1'b0, eac_pkg::OFS_ADDRESS_HIGH, 8'h00, d);
		cmp(d, 8'h01);
		i_cpu.acc(1'b1, 1'b1, eac_pkg::OFS_CONTROL, 8'hf8, d);
		i_cpu.acc(1'b0, 1'b1, eac_pkg::OFS_CONTROL, 8'h00, d);
		cmp(d, 8'h08);
		i_cpu.acc(1'b0, 1'b0, 7'h05, 8'h00, d);
		cmp(d, 8'h00);
		cmp({7'h00, ready_irq}, 8'h00);
		@(posedge clk_sys);
		global_irq_enable <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		cmp({7'h00, ready_irq}, 8'h01);
		@(posedge clk_sys);
		global_irq_enable <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			s0 = stalls;
			i_cpu.nv_write(i[0], adr[i], dat[i]);
			t0 = cycles;
			i_cpu.acc(1'b0, 1'b0, eac_pkg::OFS_CONTROL, 8'h00, d);
			cmp(d & 8'h02, 8'h02);
			if (i == 1) begin
				i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_ADDRESS_LOW, 8'h00, d);
				i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_CONTROL, 8'h01, d);
				i_cpu.acc(1'b0, 1'b0, eac_pkg::OFS_DATA, 8'h00, d);
				cmp(d, dat[1]);
				i_cpu.acc(1'b0, 1'b0, eac_pkg::OFS_ADDRESS_LOW, 8'h00, d);
				cmp(d, 8'hff);
				@(posedge clk_sys);
				rst_b             <= 1'b0;
				global_irq_enable <= 1'b1;
				repeat (2) @(posedge clk_sys);
				rst_b <= 1'b1;
				i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_CONTROL, 8'h08, d);
				i_cpu.acc(1'b0, 1'b0, eac_pkg::OFS_CONTROL, 8'h00, d);
				cmp(d & 8'h02, 8'h02);
				cmp({7'h00, ready_irq}, 8'h00);
				repeat (30) @(posedge clk_sys);
				i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_CONTROL, 8'h0c, d);
				i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_CONTROL, 8'h0a, d);
			end
			i_cpu.nv_idle();
			cmp_cnt(cycles - t0, 88, 114);
			cmp_cnt(stalls - s0, 2, 2);
			repeat (2) @(posedge clk_sys);
			#1;
			cmp({7'h00, ready_irq}, {7'h00, i == 1});
			@(posedge clk_sys);
			global_irq_enable <= 1'b0;
		end
		for (int i = 0; i < 3; i++) begin
			s0 = stalls;
			i_cpu.nv_read(~i[0], adr[i], d);
			cmp(d, dat[i]);
			cmp_cnt(stalls - s0, 4, 4);
		end
		i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_DATA, 8'hee, d);
		i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_CONTROL, 8'h02, d);
		i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_CONTROL, 8'h04, d);
		i_cpu.acc(1'b0, 1'b0, eac_pkg::OFS_CONTROL, 8'h00, d);
		cmp(d, 8'h04);
		repeat (3) @(posedge clk_sys);
		i_cpu.acc(1'b0, 1'b0, eac_pkg::OFS_CONTROL, 8'h00, d);
		cmp(d, 8'h00);
		i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_CONTROL, 8'h02, d);
		@(posedge clk_sys);
		flash_selfprog_enable <= 1'b1;
		i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_CONTROL, 8'h04, d);
		i_cpu.acc(1'b1, 1'b0, eac_pkg::OFS_CONTROL, 8'h02, d);
		i_cpu.acc(1'b0, 1'b0, eac_pkg::OFS_CONTROL, 8'h00, d);
		cmp(d & 8'h02, 8'h00);
		@(posedge clk_sys);
		flash_selfprog_enable <= 1'b0;
		i_cpu.nv_read(1'b0, 9'h000, d);
		cmp(d, 8'h3c);
		stop_test();
	end
endmodule : eac_top_tb
